// [bench/sxf_flow_chk.sv]
// concurrent checks on the top-level ports of the xon/xoff flow control block
// assumes one clock domain with synchronous active-low reset; bound from the bench
`include "sxf_params.svh"
module sxf_flow_chk (
    input wire logic       I_SYS_CLK,
    input wire logic       I_RST_B,
    input wire logic       I_RX_VALID,
    input wire logic [7:0] I_RX_DATA,
    input wire logic       O_RX_READY,
    input wire logic       O_RX_OVERFLOW,
    input wire logic       O_RXB_VALID,
    input wire logic [7:0] O_RXB_DATA,
    input wire logic       I_RXB_READY,
    input wire logic       I_TX_VALID,
    input wire logic [7:0] I_TX_DATA,
    input wire logic       O_TX_READY,
    input wire logic       O_SER_VALID,
    input wire logic [7:0] O_SER_DATA,
    input wire logic       I_SER_READY,
    input wire logic       I_ARG_VALID,
    input wire logic [7:0] I_ARG_DATA,
    input wire logic       I_ONL,
    input wire logic       O_ARG_ERR,
    input wire logic       O_RSP_VALID,
    input wire logic [7:0] O_RSP_DATA,
    input wire logic       I_RSP_READY,
    input wire logic       O_TX_FLOW_EN,
    input wire logic       O_RX_FLOW_EN,
    input wire logic       O_TX_PAUSED
);
    timeunit 1ns;
    timeprecision 1ps;
    // a bare CR is a query only if no argument character came before it
    logic arg_seen_r;

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B || I_ONL || (I_ARG_VALID && I_ARG_DATA == `SXF_CHAR_CR))
            arg_seen_r <= 1'b0;
        else if (I_ARG_VALID && I_ARG_DATA != `SXF_CHAR_SPACE)
            arg_seen_r <= 1'b1;
    end

    reset_off_a: assert property (
        $rose(I_RST_B) |-> !O_TX_FLOW_EN && !O_RX_FLOW_EN && !O_TX_PAUSED)
        else $error("flow state not cleared by reset");
    stop_pause_a: assert property (
        I_RX_VALID && I_RX_DATA == `SXF_CHAR_XOFF && O_TX_FLOW_EN && !I_ONL |=> O_TX_PAUSED)
        else $error("stop char did not pause output");
    start_resume_a: assert property (
        I_RX_VALID && I_RX_DATA == `SXF_CHAR_XON && O_TX_FLOW_EN && !I_ONL |=> !O_TX_PAUSED)
        else $error("start char did not resume output");
    paused_quiet_a: assert property (
        O_TX_PAUSED && O_TX_FLOW_EN && !O_SER_VALID && !I_RX_VALID && !I_ONL && !I_ARG_VALID
        |=> !O_SER_VALID || O_SER_DATA inside {`SXF_CHAR_XON, `SXF_CHAR_XOFF})
        else $error("data launched while paused");
    ser_hold_a: assert property (
        O_SER_VALID && !I_SER_READY |=> O_SER_VALID && $stable(O_SER_DATA))
        else $error("serial char changed before accepted");
    onl_clear_a: assert property (
        I_ONL |=> !O_TX_FLOW_EN && !O_RX_FLOW_EN)
        else $error("online reset left flow enabled");
    setting_hold_a: assert property (
        (!I_ARG_VALID && !I_ONL) [*2] |=> $stable({O_TX_FLOW_EN, O_RX_FLOW_EN}))
        else $error("settings changed without command");
    query_first_a: assert property (
        I_ARG_VALID && I_ARG_DATA == `SXF_CHAR_CR && !arg_seen_r && !O_RSP_VALID && !I_ONL
        |=> O_RSP_VALID && O_RSP_DATA == (`SXF_CHAR_ZERO | {7'h00, O_TX_FLOW_EN}))
        else $error("query reply missing or wrong");
    reply_hold_a: assert property (
        O_RSP_VALID && !I_RSP_READY |=> O_RSP_VALID && $stable(O_RSP_DATA))
        else $error("reply byte changed before taken");

    xoff_out_c: cover property (O_SER_VALID && O_SER_DATA == `SXF_CHAR_XOFF && O_RX_FLOW_EN);
    overflow_c: cover property (O_RX_OVERFLOW);
    paused_c:   cover property (O_TX_PAUSED && O_TX_FLOW_EN);
endmodule : sxf_flow_chk

// [bench/sxf_flow_tb.sv]
// self-checking bench for the xon/xoff flow control block
// assumes sxf_params.svh on the include path; the peer stands on the serial side
`include "sxf_params.svh"
module sxf_flow_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       I_SYS_CLK = 1'b0;
    logic       I_RST_B = 1'b0;
    logic       I_RX_VALID, O_RX_READY, O_RX_OVERFLOW, O_RXB_VALID, O_TX_READY;
    logic       I_RXB_READY = 1'b0;
    logic       I_TX_VALID = 1'b0;
    logic       I_ARG_VALID = 1'b0;
    logic       I_ONL = 1'b0;
    logic       I_RSP_READY = 1'b0;
    logic       O_SER_VALID, I_SER_READY, O_ARG_ERR, O_RSP_VALID;
    logic       O_TX_FLOW_EN, O_RX_FLOW_EN, O_TX_PAUSED;
    logic [7:0] I_RX_DATA, O_RXB_DATA, O_SER_DATA, O_RSP_DATA;
    logic [7:0] I_TX_DATA = 8'h00;
    logic [7:0] I_ARG_DATA = 8'h00;
    int         num_errors = 0;
    int         tests_run = 0;
    int         ovf_cnt = 0;
    int         err_cnt = 0;

    sxf_flow uut (.*);
    sxf_peer peer (.clk(I_SYS_CLK), .rst_b(I_RST_B), .ser_valid(O_SER_VALID),
        .ser_data(O_SER_DATA), .ser_ready(I_SER_READY), .rx_valid(I_RX_VALID),
        .rx_data(I_RX_DATA));

    always #5 I_SYS_CLK = ~I_SYS_CLK;

    always @(posedge I_SYS_CLK) begin
        if (O_RX_OVERFLOW === 1'b1) ovf_cnt++;
        if (O_ARG_ERR === 1'b1) err_cnt++;
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge I_SYS_CLK);
        #1;
    endtask : tick

    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    task automatic stop_test();
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    // argument characters back to back, closed by CR
    task automatic arg(input string s);
        I_ARG_VALID = 1'b1;
        for (int i = 0; i < s.len(); i++) begin
            I_ARG_DATA = s[i];
            tick();
        end
        I_ARG_DATA = `SXF_CHAR_CR;
        tick();
        I_ARG_VALID = 1'b0;
        tick(2);
    endtask : arg

    task automatic flow(input logic t, input logic r);
        chk(O_TX_FLOW_EN === t && O_RX_FLOW_EN === r, "flow setting");
    endtask : flow

    // ready is held back first so the reply must wait for the host
    task automatic query(input logic t, input logic r);
        logic [7:0] e[5];
        int         k;
        e = '{`SXF_CHAR_ZERO | t, `SXF_CHAR_COMMA, `SXF_CHAR_ZERO | r, `SXF_CHAR_CR,
              `SXF_CHAR_LF};
        k = 0;
        arg("");
        I_RSP_READY = 1'b1;
        for (int n = 0; n < 20 && k < 5; n++) begin
            if (O_RSP_VALID === 1'b1) begin
                chk(O_RSP_DATA === e[k], "reply byte");
                k++;
            end
            tick();
        end
        I_RSP_READY = 1'b0;
        chk(k == 5 && O_RSP_VALID === 1'b0, "reply length");
    endtask : query

    task automatic host_tx(input logic [7:0] b);
        I_TX_VALID = 1'b1;
        I_TX_DATA = b;
        for (int n = 0; n < 50 && O_TX_READY !== 1'b1; n++) tick();
        tick();
        I_TX_VALID = 1'b0;
    endtask : host_tx

    task automatic t_cmds();
        arg("1,1");
        flow(1'b1, 1'b1);
        query(1'b1, 1'b1);
        arg(",0");
        flow(1'b1, 1'b0);
        arg("x");
        flow(1'b1, 1'b0);
        chk(err_cnt == 1, "bad argument flag");
        I_ONL = 1'b1;
        tick();
        I_ONL = 1'b0;
        tick();
        flow(1'b0, 1'b0);
        query(1'b0, 1'b0);
    endtask : t_cmds

    task automatic t_txflow();
        arg("1");
        flow(1'b1, 1'b0);
        peer.got.delete();
        peer.send(`SXF_CHAR_XOFF);
        chk(O_TX_PAUSED === 1'b1, "pause after stop char");
        host_tx(8'h55);
        tick(20);
        chk(peer.got.size() == 0 && O_RXB_VALID === 1'b0, "held while paused");
        peer.send(`SXF_CHAR_XON);
        tick(5);
        chk(peer.got.size() == 1 && O_RXB_VALID === 1'b0, "resume");
        chk(peer.got[0] === 8'h55, "resumed byte");
    endtask : t_txflow

    // peer ignores the stop char and stalls, so the buffer overruns by one
    task automatic t_rxflow();
        int k;
        k = 0;
        arg("0,1");
        flow(1'b0, 1'b1);
        peer.got.delete();
        peer.stall = 1'b1;
        peer.obey = 1'b0;
        for (int i = 0; i < 10; i++) peer.send(8'h40 + i[7:0]);
        tick();
        chk(ovf_cnt == 1, "one byte lost");
        chk(O_SER_VALID === 1'b1 && O_SER_DATA === `SXF_CHAR_XOFF, "stop char out");
        chk(O_RX_READY === 1'b0, "full buffer not ready");
        peer.stall = 1'b0;
        I_RXB_READY = 1'b1;
        for (int n = 0; n < 60 && k < 9; n++) begin
            if (O_RXB_VALID === 1'b1) begin
                chk(O_RXB_DATA === 8'h40 + k[7:0], "rx order");
                k++;
            end
            tick();
        end
        I_RXB_READY = 1'b0;
        tick(3);
        chk(k == 9 && peer.got.size() == 2, "flow char count");
        chk(peer.got[0] === `SXF_CHAR_XOFF && peer.got[1] === `SXF_CHAR_XON, "flow chars");
        peer.obey = 1'b1;
        // with tx flow control off a stop char is plain data
        peer.send(`SXF_CHAR_XOFF);
        tick(2);
        chk(O_RXB_VALID === 1'b1 && O_RXB_DATA === `SXF_CHAR_XOFF, "stop char stored");
        chk(O_TX_PAUSED === 1'b0 && O_RX_READY === 1'b1, "no pause when off");
    endtask : t_rxflow

    initial begin
        tick(4);
        I_RST_B = 1'b1;
        tick();
        chk(O_TX_FLOW_EN === 1'b0 && O_RX_FLOW_EN === 1'b0 && O_TX_READY === 1'b1,
            "reset state");
        t_cmds();
        t_txflow();
        t_rxflow();
        stop_test();
    end

    initial begin
        tick(5000);
        num_errors++;
        stop_test();
    end
endmodule : sxf_flow_tb

bind sxf_flow sxf_flow_chk chk (.*);

// [bench/sxf_peer.sv]
// far serial device that speaks software flow control, plus the uart tx accept
// assumes the bench calls send and sets stall/obey between clock edges
`include "sxf_params.svh"
module sxf_peer (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ser_valid,
    input  wire logic [7:0] ser_data,
    output logic            ser_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       stall = 1'b0;
    logic       obey  = 1'b1;
    logic       held  = 1'b0;
    logic [7:0] got[$];

    initial rx_valid = 1'b0;
    initial rx_data = 8'h00;
    assign ser_ready = !stall;

    always @(posedge clk) begin
        if (rst_b && ser_valid && ser_ready) begin
            got.push_back(ser_data);
            if (ser_data == `SXF_CHAR_XOFF) held <= 1'b1;
            if (ser_data == `SXF_CHAR_XON) held <= 1'b0;
        end
    end

    // data line shows the inverse afterwards so a late read of it is caught
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        while (obey && held && n < 500) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        rx_valid = 1'b1;
        rx_data = b;
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~b;
    endtask : send
endmodule : sxf_peer

// [verilog/sxf_fifo.sv]
// synchronous fifo holding received serial bytes
// assumes synchronous active-low reset; count is exact occupancy
`include "sxf_params.svh"
module sxf_fifo #(
    parameter int WIDTH = `SXF_FIFO_WIDTH,
    parameter int DEPTH = `SXF_FIFO_DEPTH,
    parameter int AW    = `SXF_FIFO_AW
) (
    // clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_rst_b,
    // stream ports
    sxf_fifo_if.buf_side fb
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign fb.in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign fb.out_valid = (cnt_r != '0);
    assign fb.out_data  = mem[rd_ptr_r];
    assign fb.count     = `SXF_CNT_W'(cnt_r);
    assign push         = fb.in_valid && fb.in_ready;
    assign pop          = fb.out_valid && fb.out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= fb.in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : sxf_fifo

// [verilog/sxf_fifo_if.sv]
// valid/ready carrier between the flow control core and its receive buffer
// assumes both ends run on the same clock
`include "sxf_params.svh"
interface sxf_fifo_if;
    logic                      in_valid;
    logic                      in_ready;
    logic [`SXF_FIFO_WIDTH-1:0] in_data;
    logic                      out_valid;
    logic                      out_ready;
    logic [`SXF_FIFO_WIDTH-1:0] out_data;
    logic [`SXF_CNT_W-1:0]     count;

    modport buf_side (
        input  in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data, count
    );
    modport user_side (
        output in_valid, in_data, out_ready,
        input  in_ready, out_valid, out_data, count
    );
endinterface : sxf_fifo_if

// [verilog/sxf_flow.sv]
// xon/xoff software flow control between a uart and the host side
// assumes uart rx/tx byte handshakes and the command parser share I_SYS_CLK;
// the parser forwards only the argument characters of the xon command
`include "sxf_params.svh"
module sxf_flow (
    // clock and reset
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RST_B,
    // received serial bytes from the uart receiver
    input  wire logic       I_RX_VALID,
    input  wire logic [7:0] I_RX_DATA,
    output logic            O_RX_READY,
    output logic            O_RX_OVERFLOW,
    // buffered received bytes toward the host
    output logic            O_RXB_VALID,
    output logic [7:0]      O_RXB_DATA,
    input  wire logic       I_RXB_READY,
    // host bytes to be sent on the serial line
    input  wire logic       I_TX_VALID,
    input  wire logic [7:0] I_TX_DATA,
    output logic            O_TX_READY,
    // characters toward the uart transmitter
    output logic            O_SER_VALID,
    output logic [7:0]      O_SER_DATA,
    input  wire logic       I_SER_READY,
    // xon command arguments and online reset
    input  wire logic       I_ARG_VALID,
    input  wire logic [7:0] I_ARG_DATA,
    input  wire logic       I_ONL,
    output logic            O_ARG_ERR,
    // settings reply toward the host
    output logic            O_RSP_VALID,
    output logic [7:0]      O_RSP_DATA,
    input  wire logic       I_RSP_READY,
    // current state
    output logic            O_TX_FLOW_EN,
    output logic            O_RX_FLOW_EN,
    output logic            O_TX_PAUSED
);
    function automatic sxf_pkg::sxf_byte_t bool_char(input logic b);
        return b ? `SXF_CHAR_ONE : `SXF_CHAR_ZERO;
    endfunction : bool_char

    // reply byte by position: tx digit, comma, rx digit, CR, LF
    function automatic sxf_pkg::sxf_byte_t reply_char(input logic [2:0] idx,
                                                      input logic       t,
                                                      input logic       r);
        case (idx)
            3'h0:    return bool_char(t);
            3'h1:    return `SXF_CHAR_COMMA;
            3'h2:    return bool_char(r);
            3'h3:    return `SXF_CHAR_CR;
            default: return `SXF_CHAR_LF;
        endcase
    endfunction : reply_char

    function automatic logic is_bool_char(input sxf_pkg::sxf_byte_t c);
        return (c == `SXF_CHAR_ZERO) || (c == `SXF_CHAR_ONE);
    endfunction : is_bool_char

    sxf_fifo_if fif ();

    sxf_fifo #(
        .WIDTH (`SXF_FIFO_WIDTH),
        .DEPTH (`SXF_FIFO_DEPTH),
        .AW    (`SXF_FIFO_AW)
    ) u_rx_buf (
        .i_clk   (I_SYS_CLK),
        .i_rst_b (I_RST_B),
        .fb      (fif.buf_side)
    );

    // settings and flow state
    logic                 tx_en_r;
    logic                 rx_en_r;
    logic                 paused_r;
    logic                 xoff_sent_r;
    // argument parser
    sxf_pkg::sxf_arg_st_t arg_st_r;
    logic                 have_tx_r;
    logic                 have_rx_r;
    logic                 tx_val_r;
    logic                 rx_val_r;
    logic                 commit;
    logic                 query;
    // reply
    logic                 rsp_busy_r;
    logic [2:0]           rsp_idx_r;
    logic                 rsp_tx_r;
    logic                 rsp_rx_r;
    sxf_pkg::sxf_byte_t   rsp_data_r;
    logic                 tx_ready_r;
    // transmit path
    logic                 hold_valid_r;
    sxf_pkg::sxf_byte_t   hold_data_r;
    logic                 ser_valid_r;
    sxf_pkg::sxf_byte_t   ser_data_r;
    logic                 slot_free;
    logic                 need_xoff;
    logic                 need_xon;
    logic                 send_xoff;
    logic                 send_xon;
    logic                 send_data;
    logic                 take_tx;
    // receive path
    logic                 rx_is_xon;
    logic                 rx_is_xoff;
    logic                 rx_consume;
    logic                 rxb_valid_r;
    sxf_pkg::sxf_byte_t   rxb_data_r;
    logic                 rxb_load;
    logic                 rx_ready_r;
    logic                 overflow_r;
    logic                 arg_err_r;

    // receive filter: flow characters are eaten only while tx flow control is on
    assign rx_is_xon  = I_RX_VALID && (I_RX_DATA == `SXF_CHAR_XON);
    assign rx_is_xoff = I_RX_VALID && (I_RX_DATA == `SXF_CHAR_XOFF);
    assign rx_consume = tx_en_r && (rx_is_xon || rx_is_xoff);

    assign fif.in_valid  = I_RX_VALID && !rx_consume;
    assign fif.in_data   = I_RX_DATA;
    assign rxb_load      = !rxb_valid_r || I_RXB_READY;
    assign fif.out_ready = rxb_load;

    // argument commit on carriage return
    assign commit = I_ARG_VALID && (I_ARG_DATA == `SXF_CHAR_CR) && (arg_st_r != sxf_pkg::SXF_ARG_BAD);
    assign query  = commit && (arg_st_r == sxf_pkg::SXF_ARG_TX) && !have_tx_r;

    // flow character requests toward the serial line
    assign need_xoff = rx_en_r && !xoff_sent_r && (fif.count >= `SXF_NEAR_FULL);
    // a sender left in xoff when rx flow control is turned off would hang, so release it
    assign need_xon  = xoff_sent_r && (!rx_en_r || (fif.count <= `SXF_RESUME_LVL));

    // a new character enters the output register only after the last one was taken
    assign slot_free = !ser_valid_r || I_SER_READY;
    assign send_xoff = slot_free && need_xoff;
    assign send_xon  = slot_free && !need_xoff && need_xon;
    assign send_data = slot_free && !need_xoff && !need_xon && hold_valid_r
                       && !(tx_en_r && paused_r);
    assign take_tx   = I_TX_VALID && O_TX_READY;

    // settings
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            tx_en_r <= 1'b0;
            rx_en_r <= 1'b0;
        end else if (I_ONL) begin
            tx_en_r <= 1'b0;
            rx_en_r <= 1'b0;
        end else if (commit) begin
            if (have_tx_r) begin
                tx_en_r <= tx_val_r;
            end
            if (have_rx_r) begin
                rx_en_r <= rx_val_r;
            end
        end
    end

    // argument parser
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B || I_ONL) begin
            arg_st_r  <= sxf_pkg::SXF_ARG_TX;
            have_tx_r <= 1'b0;
            have_rx_r <= 1'b0;
            tx_val_r  <= 1'b0;
            rx_val_r  <= 1'b0;
            arg_err_r <= 1'b0;
        end else begin
            arg_err_r <= 1'b0;
            if (I_ARG_VALID) begin
                if (I_ARG_DATA == `SXF_CHAR_CR) begin
                    arg_err_r <= (arg_st_r == sxf_pkg::SXF_ARG_BAD);
                    arg_st_r  <= sxf_pkg::SXF_ARG_TX;
                    have_tx_r <= 1'b0;
                    have_rx_r <= 1'b0;
                end else if (I_ARG_DATA != `SXF_CHAR_SPACE) begin
                    case (arg_st_r)
                        sxf_pkg::SXF_ARG_TX: begin
                            if (is_bool_char(I_ARG_DATA)) begin
                                have_tx_r <= 1'b1;
                                tx_val_r  <= I_ARG_DATA[0];
                            end else if (I_ARG_DATA == `SXF_CHAR_COMMA) begin
                                arg_st_r <= sxf_pkg::SXF_ARG_RX;
                            end else begin
                                arg_st_r <= sxf_pkg::SXF_ARG_BAD;
                            end
                        end
                        sxf_pkg::SXF_ARG_RX: begin
                            if (is_bool_char(I_ARG_DATA)) begin
                                have_rx_r <= 1'b1;
                                rx_val_r  <= I_ARG_DATA[0];
                            end else begin
                                arg_st_r <= sxf_pkg::SXF_ARG_BAD;
                            end
                        end
                        default: begin
                            arg_st_r <= sxf_pkg::SXF_ARG_BAD;
                        end
                    endcase
                end
            end
        end
    end

    // settings reply; a query arriving while one is still going out is dropped
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            rsp_busy_r <= 1'b0;
            rsp_idx_r  <= '0;
            rsp_tx_r   <= 1'b0;
            rsp_rx_r   <= 1'b0;
            rsp_data_r <= '0;
        end else if (!rsp_busy_r) begin
            if (query) begin
                rsp_busy_r <= 1'b1;
                rsp_idx_r  <= '0;
                rsp_tx_r   <= tx_en_r;
                rsp_rx_r   <= rx_en_r;
                rsp_data_r <= reply_char(3'h0, tx_en_r, rx_en_r);
            end
        end else if (I_RSP_READY) begin
            if (rsp_idx_r == `SXF_RSP_LAST) begin
                rsp_busy_r <= 1'b0;
            end
            rsp_idx_r  <= rsp_idx_r + 3'h1;
            // next byte is registered so the output comes straight from a flop
            rsp_data_r <= reply_char(rsp_idx_r + 3'h1, rsp_tx_r, rsp_rx_r);
        end
    end

    assign O_RSP_VALID = rsp_busy_r;
    assign O_RSP_DATA  = rsp_data_r;

    // pause state of outgoing data
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B || I_ONL) begin
            paused_r <= 1'b0;
        end else if (!tx_en_r) begin
            paused_r <= 1'b0;
        end else if (rx_is_xoff) begin
            paused_r <= 1'b1;
        end else if (rx_is_xon) begin
            paused_r <= 1'b0;
        end
    end

    // receive-side flow: remembers that the far sender was told to stop
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            xoff_sent_r <= 1'b0;
        end else if (send_xoff) begin
            xoff_sent_r <= 1'b1;
        end else if (send_xon) begin
            xoff_sent_r <= 1'b0;
        end
    end

    // one-byte holding stage for host data
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            hold_valid_r <= 1'b0;
            hold_data_r  <= '0;
            tx_ready_r   <= 1'b1;
        end else if (take_tx) begin
            hold_valid_r <= 1'b1;
            hold_data_r  <= I_TX_DATA;
            tx_ready_r   <= 1'b0;
        end else if (send_data) begin
            hold_valid_r <= 1'b0;
            tx_ready_r   <= 1'b1;
        end
    end
    // ready only while the holding stage is empty, so a taken byte is never overwritten
    assign O_TX_READY = tx_ready_r;

    // serial output register
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            ser_valid_r <= 1'b0;
            ser_data_r  <= '0;
        end else if (slot_free) begin
            ser_valid_r <= send_xoff || send_xon || send_data;
            if (send_xoff) begin
                ser_data_r <= `SXF_CHAR_XOFF;
            end else if (send_xon) begin
                ser_data_r <= `SXF_CHAR_XON;
            end else if (send_data) begin
                ser_data_r <= hold_data_r;
            end
        end
    end

    // registered buffer output stage toward the host
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            rxb_valid_r <= 1'b0;
            rxb_data_r  <= '0;
        end else if (rxb_load) begin
            rxb_valid_r <= fif.out_valid;
            if (fif.out_valid) begin
                rxb_data_r <= fif.out_data;
            end
        end
    end

    // overflow pulse when a data byte meets a full buffer; the byte is lost
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            overflow_r <= 1'b0;
            rx_ready_r <= 1'b0;
        end else begin
            overflow_r <= fif.in_valid && !fif.in_ready;
            rx_ready_r <= fif.in_ready;
        end
    end

    assign O_RX_READY    = rx_ready_r;
    assign O_RX_OVERFLOW = overflow_r;
    assign O_RXB_VALID   = rxb_valid_r;
    assign O_RXB_DATA    = rxb_data_r;
    assign O_SER_VALID   = ser_valid_r;
    assign O_SER_DATA    = ser_data_r;
    assign O_ARG_ERR     = arg_err_r;
    assign O_TX_FLOW_EN  = tx_en_r;
    assign O_RX_FLOW_EN  = rx_en_r;
    assign O_TX_PAUSED   = paused_r;
endmodule : sxf_flow

// [verilog/sxf_params.svh]
// timing-free constants for the serial xon/xoff flow control block
// assumes one 100 MHz clock and byte-wide uart streams on both sides
// What this block does
// - with transmit flow control on, a received XOFF (19) stops new outgoing data one clock after it arrives.
// - with transmit flow control on and output paused, a received XON (17) resumes output.
// - with receive flow control on, an XOFF goes out when the receive buffer is nearly full.
// - with receive flow control on and XOFF sent, an XON goes out once the buffer drains.
// - both transmit and receive flow control are off after power-on reset.
// - the command takes optional tx then optional rx; a leading comma sets rx alone.
// - the command with no argument replies "t,r" then CR LF, each 1 for on or 0 for off.
// - settings hold until changed, the online-reset command, or power loss.
`ifndef SXF_PARAMS_SVH
`define SXF_PARAMS_SVH

`define SXF_CHAR_XON     8'h11
`define SXF_CHAR_XOFF    8'h13
`define SXF_CHAR_CR      8'h0d
`define SXF_CHAR_LF      8'h0a
`define SXF_CHAR_COMMA   8'h2c
`define SXF_CHAR_SPACE   8'h20
`define SXF_CHAR_ZERO    8'h30
`define SXF_CHAR_ONE     8'h31

`define SXF_FIFO_WIDTH   8
`define SXF_FIFO_DEPTH   8
`define SXF_FIFO_AW      3
`define SXF_CNT_W        4
`define SXF_NEAR_FULL    4'h6
`define SXF_RESUME_LVL   4'h2

`define SXF_RSP_LEN      3'h5
`define SXF_RSP_LAST     3'h4

`endif

// [verilog/sxf_pkg.sv]
// types used by the flow control block: byte and argument parser state
// assumes sxf_params.svh is on the include path
`include "sxf_params.svh"
package sxf_pkg;
    typedef logic [7:0] sxf_byte_t;

    typedef enum logic [1:0] {
        SXF_ARG_TX  = 2'b00,
        SXF_ARG_RX  = 2'b01,
        SXF_ARG_BAD = 2'b10
    } sxf_arg_st_t;
endpackage : sxf_pkg
